// File: include/tcoil_defines.svh
// timing counts, reset values and fixed codes of the telecoil switching block
`ifndef TCOIL_DEFINES_SVH
`define TCOIL_DEFINES_SVH

// memory slot entered while the telecoil switch is closed
`define TCOIL_MEMORY 2'h3
// memory slot active after reset
`define TCOIL_MEMORY_RST 2'h0
// sample period of the switch input in ns, and its count of 8 ns clock cycles
`define TCOIL_SAMPLE_NS 1000
`define TCOIL_CLK_NS 8
`define TCOIL_SAMPLE_CYC (`TCOIL_SAMPLE_NS / `TCOIL_CLK_NS)
// debounce counter reset value and least usable period (in samples)
`define TCOIL_CNT_RST 16'h0000
`define TCOIL_PERIOD_MIN 16'h0001

`endif

// File: include/tcoil_pkg.sv
// types shared by the telecoil switching block
package tcoil_pkg;

    // switching state: normal selection, held in telecoil, debouncing an opening
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_TCOIL = 2'b01,
        ST_DEBOUNCE = 2'b10
    } tc_state_type;

    // configuration that travels together into the block
    typedef struct packed {
        logic auto_en;
        logic polarity;
        logic [15:0] period;
    } tc_cfg_type;

    // all state of the switching block
    typedef struct packed {
        tc_state_type st;
        logic [1:0] active;
        logic [1:0] saved;
        logic [15:0] cnt;
    } tc_reg_type;

    // all state of the sample divider
    typedef struct packed {
        logic [15:0] div;
        logic tick;
    } div_reg_type;

endpackage

// File: rtl/sample_tick_divider.sv
// divider that makes the one-cycle switch sampling enable
`timescale 1ns/10ps
`include "tcoil_defines.svh"
module sample_tick_divider
    import tcoil_pkg::*;
#(
    parameter logic [15:0] DIV = 16'(`TCOIL_SAMPLE_CYC)
) (
    input wire logic clk,
    input wire logic reset,
    output logic tick
);
    div_reg_type r_ff;
    div_reg_type nxt_r;

    // count down and pulse once per wrap; a divide of 0 or 1 ticks every cycle
    always_comb begin
        nxt_r = r_ff;
        nxt_r.tick = 1'b0;
        if (r_ff.div == 16'h0000 || DIV <= 16'h0001) begin
            nxt_r.div = DIV - 16'h0001;
            nxt_r.tick = 1'b1;
        end else begin
            nxt_r.div = r_ff.div - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign tick = r_ff.tick;

    // the enable must never fire on two cycles in a row once DIV is above one
    a_tick_spacing: assert property (@(posedge clk) disable iff (reset)
        (tick && DIV > 16'h0001) |=> !tick)
        else $error("sample enable fired on consecutive cycles");
endmodule

// File: rtl/telecoil_switch_debounce.sv
// automatic telecoil memory switching with a programmable debounce on opening
//
// Overview of operation
// [RQ1] closed switch with feature on selects memory four
// [RQ2] after debounced opening, restore the previous memory
// [RQ3] debounce period comes from a programmable setting
// [RQ4] closed-to-open change starts repeated monitoring
// [RQ5] leave memory four only after whole period open
// [RQ6] closed level follows the pull-up/pull-down setting
// [RQ7] any closed sample restarts the open count
//
// normal follows the requested memory; telecoil pins memory four; debounce
// keeps memory four while open samples are counted toward the period.
// the select input is taken as synchronous: a raw contact must be
// synchronised before it reaches this block, or a metastable sample can
// count as open or closed at random.
// the period is read live, so shortening it mid-debounce can end the wait
// early; that trade keeps the count free of a shadow copy of the setting.
// dropping the feature while in telecoil restores the kept memory at once.
`timescale 1ns/10ps
`include "tcoil_defines.svh"
module telecoil_switch_debounce
    import tcoil_pkg::*;
#(
    parameter logic [15:0] SAMPLE_DIV = 16'(`TCOIL_SAMPLE_CYC)
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic AUTO_TCOIL_EN,
    input wire logic SELECT_INPUT_POLARITY_SETTING,
    input wire logic [15:0] DEBOUNCE_PERIOD,
    input wire logic SECOND_MEMORY_SELECT_INPUT,
    input wire logic [1:0] REQUESTED_MEMORY,
    output logic [1:0] ACTIVE_MEMORY,
    output logic TCOIL_ACTIVE
);
    tc_cfg_type cfg;
    tc_reg_type r_ff;
    tc_reg_type nxt_r;
    logic sample_tick;
    logic sw_closed;
    logic [15:0] period_eff;
    logic [16:0] cnt_inc;
    logic period_done;

    // gather configuration pins into one carrier
    assign cfg = '{auto_en: AUTO_TCOIL_EN, polarity: SELECT_INPUT_POLARITY_SETTING,
                   period: DEBOUNCE_PERIOD};

    sample_tick_divider #(
        .DIV(SAMPLE_DIV)
    ) u_div (
        .clk(MCLK),
        .reset(RESET),
        .tick(sample_tick)
    );

    // polarity 1 = pulldown (closed reads high), 0 = pullup (closed reads low)
    assign sw_closed = (SECOND_MEMORY_SELECT_INPUT == cfg.polarity); // [RQ6]

    // clamp a period of zero to one; either value releases on the first open sample of debounce
    assign period_eff = (cfg.period < `TCOIL_PERIOD_MIN) ? `TCOIL_PERIOD_MIN : cfg.period; // [RQ3]
    assign cnt_inc = {1'b0, r_ff.cnt} + 17'h0_0001;
    assign period_done = (cnt_inc >= {1'b0, period_eff}); // [RQ3]

    // next-state logic; the switch is only looked at on sample enables, so a
    // bounce shorter than one sample period is seen only if it covers an enable
    // the first open sample only moves telecoil to debounce and is not counted,
    // so the release needs a full period of further open samples
    always_comb begin
        nxt_r = r_ff;
        unique case (r_ff.st)
            ST_NORMAL: begin
                nxt_r.active = REQUESTED_MEMORY;
                nxt_r.cnt = `TCOIL_CNT_RST;
                if (cfg.auto_en && sample_tick && sw_closed) begin
                    nxt_r.saved = r_ff.active; // memory in use before the jump
                    nxt_r.active = `TCOIL_MEMORY; // [RQ1]
                    nxt_r.st = ST_TCOIL;
                end
            end
            ST_TCOIL: begin
                nxt_r.active = `TCOIL_MEMORY;
                nxt_r.cnt = `TCOIL_CNT_RST;
                if (sample_tick && !sw_closed) begin
                    nxt_r.st = ST_DEBOUNCE; // [RQ4] watch rather than act
                end
            end
            ST_DEBOUNCE: begin
                nxt_r.active = `TCOIL_MEMORY;
                if (sample_tick) begin
                    if (sw_closed) begin
                        nxt_r.st = ST_TCOIL; // [RQ7] bounce seen, start over
                        nxt_r.cnt = `TCOIL_CNT_RST; // [RQ7]
                    end else if (period_done) begin
                        nxt_r.st = ST_NORMAL; // [RQ5] open for the whole period
                        nxt_r.active = r_ff.saved; // [RQ2]
                        nxt_r.cnt = `TCOIL_CNT_RST;
                    end else begin
                        nxt_r.cnt = cnt_inc[15:0]; // [RQ5]
                    end
                end
            end
            default: begin
                nxt_r.st = ST_NORMAL;
                nxt_r.active = `TCOIL_MEMORY_RST;
                nxt_r.cnt = `TCOIL_CNT_RST;
            end
        endcase
        // turning the feature off drops telecoil at once and restores the old memory
        if (!cfg.auto_en && r_ff.st != ST_NORMAL) begin
            nxt_r.st = ST_NORMAL;
            nxt_r.active = r_ff.saved;
            nxt_r.cnt = `TCOIL_CNT_RST;
        end
    end

    // single register for all state
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            r_ff <= '{st: ST_NORMAL, active: `TCOIL_MEMORY_RST, saved: `TCOIL_MEMORY_RST,
                      cnt: `TCOIL_CNT_RST};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // memory in use and telecoil flag, both straight from the state register
    assign ACTIVE_MEMORY = r_ff.active;
    assign TCOIL_ACTIVE = (r_ff.st != ST_NORMAL);

    // every check below runs on the block clock and sleeps through reset
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    // steps of the telecoil sequence
    sequence s_close_seen;
        AUTO_TCOIL_EN && sample_tick && r_ff.st == ST_NORMAL
            && SECOND_MEMORY_SELECT_INPUT == SELECT_INPUT_POLARITY_SETTING;
    endsequence

    sequence s_open_seen;
        AUTO_TCOIL_EN && sample_tick && r_ff.st == ST_TCOIL
            && SECOND_MEMORY_SELECT_INPUT != SELECT_INPUT_POLARITY_SETTING;
    endsequence

    sequence s_open_final;
        AUTO_TCOIL_EN && sample_tick && r_ff.st == ST_DEBOUNCE && !sw_closed
            && ({1'b0, r_ff.cnt} + 17'h0_0001 >= {1'b0, period_eff});
    endsequence

    a_enter_tcoil: assert property ( // [RQ1]
            s_close_seen |=> ACTIVE_MEMORY == `TCOIL_MEMORY && TCOIL_ACTIVE)
        else $error("closed switch did not select the telecoil memory");

    a_restore_mem: assert property ( // [RQ2]
            s_open_final |=> !TCOIL_ACTIVE && ACTIVE_MEMORY == $past(r_ff.saved))
        else $error("previous memory not restored after debounce");

    a_period_respected: assert property ( // [RQ3]
            (r_ff.st == ST_DEBOUNCE && nxt_r.st == ST_NORMAL && AUTO_TCOIL_EN)
            |-> r_ff.cnt + 16'h0001 >= period_eff)
        else $error("telecoil left before the debounce period ran out");

    a_start_monitor: assert property ( // [RQ4]
            s_open_seen |=> r_ff.st == ST_DEBOUNCE && ACTIVE_MEMORY == `TCOIL_MEMORY
            && r_ff.cnt == `TCOIL_CNT_RST)
        else $error("opening acted on at once instead of debounced");

    a_hold_during_deb: assert property ( // [RQ5]
            (AUTO_TCOIL_EN && r_ff.st == ST_DEBOUNCE && sample_tick && sw_closed)
            |=> TCOIL_ACTIVE ##1 (TCOIL_ACTIVE || !$past(AUTO_TCOIL_EN)))
        else $error("telecoil left while switch still read closed");

    a_polarity_level: assert property ( // [RQ6]
            (AUTO_TCOIL_EN && sample_tick && r_ff.st == ST_NORMAL
            && SECOND_MEMORY_SELECT_INPUT != SELECT_INPUT_POLARITY_SETTING) |=> !TCOIL_ACTIVE)
        else $error("open level of the select input taken as closed");

    a_restart_count: assert property ( // [RQ7]
            (AUTO_TCOIL_EN && r_ff.st == ST_DEBOUNCE && sample_tick && sw_closed)
            |=> r_ff.st == ST_TCOIL && r_ff.cnt == `TCOIL_CNT_RST)
        else $error("closed sample did not restart the open count");

    a_count_steps: assert property ( // [RQ5]
            (AUTO_TCOIL_EN && r_ff.st == ST_DEBOUNCE && !sample_tick) |=> $stable(r_ff.cnt))
        else $error("open count moved without a sample");

    // feature dropped while telecoil or debounce is in force
    sequence s_feature_drop;
        !AUTO_TCOIL_EN && r_ff.st != ST_NORMAL;
    endsequence

    // memory four is the only memory shown while the flag stands
    a_tcoil_memory_held: assert property ( // [RQ1]
            TCOIL_ACTIVE |-> ACTIVE_MEMORY == `TCOIL_MEMORY)
        else $error("telecoil flag up with another memory in use");

    a_no_entry_off: assert property ( // [RQ1]
            (!AUTO_TCOIL_EN && r_ff.st == ST_NORMAL) |=> !TCOIL_ACTIVE)
        else $error("telecoil entered with the feature off");

    // the memory to come back to is caught at entry and then left alone
    a_saved_capture: assert property ( // [RQ2]
            s_close_seen |=> r_ff.saved == $past(r_ff.active))
        else $error("memory in use at entry was not kept");

    a_saved_steady: assert property ( // [RQ2]
            TCOIL_ACTIVE |=> $stable(r_ff.saved))
        else $error("kept memory changed during telecoil");

    a_drop_restores: assert property ( // [RQ2]
            s_feature_drop |=> !TCOIL_ACTIVE && ACTIVE_MEMORY == $past(r_ff.saved))
        else $error("feature drop did not restore the kept memory");

    // the only ways out of telecoil are the last open sample and a feature drop
    a_tcoil_stays: assert property ( // [RQ4]
            (AUTO_TCOIL_EN && r_ff.st == ST_TCOIL) |=> TCOIL_ACTIVE)
        else $error("telecoil left without a debounce");

    a_no_early_exit: assert property ( // [RQ5]
            (AUTO_TCOIL_EN && r_ff.st == ST_DEBOUNCE
            && !(sample_tick && !sw_closed && period_done)) |=> TCOIL_ACTIVE)
        else $error("debounce ended before the last open sample");
endmodule

// File: verification/reed_switch_model.sv
// reed switch on the second memory select pin, wired to either supply
`timescale 1ns/10ps
module reed_switch_model (
    input wire logic closed,
    input wire logic wired_high,
    output logic pin
);
    // closed pulls to the wired supply, open falls back to the resistor level
    assign pin = closed ? wired_high : ~wired_high;
endmodule

// File: verification/telecoil_switch_debounce_bench.sv
// random and corner tests of the telecoil switching block
`timescale 1ns/10ps
`include "tcoil_defines.svh"
module telecoil_switch_debounce_bench;
    import tcoil_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic auto_en = 1'b0;
    logic pol = 1'b0;
    logic [15:0] period = 16'h0001;
    logic closed = 1'b0;
    logic [1:0] req = 2'h0;
    logic pin;
    logic [1:0] act;
    logic tc;
    logic [1:0] act_slow;
    logic tc_slow;
    int n_mismatch = 0;
    int checks_done = 0;
    integer seed = 32'hbf6c;

    always #4 mclk = ~mclk;

    reed_switch_model sw (.closed(closed), .wired_high(pol), .pin(pin));

    // divider of one samples every clock, so counts map straight to edges
    telecoil_switch_debounce #(.SAMPLE_DIV(16'h0001)) uut (
        .MCLK(mclk),
        .RESET(rst),
        .AUTO_TCOIL_EN(auto_en),
        .SELECT_INPUT_POLARITY_SETTING(pol),
        .DEBOUNCE_PERIOD(period),
        .SECOND_MEMORY_SELECT_INPUT(pin),
        .REQUESTED_MEMORY(req),
        .ACTIVE_MEMORY(act),
        .TCOIL_ACTIVE(tc)
    );

    // a divide of three keeps the enable sparse, so the checks that matter
    // between samples get work; this copy is only compared once it settles
    telecoil_switch_debounce #(.SAMPLE_DIV(16'h0003)) uut_slow (
        .MCLK(mclk),
        .RESET(rst),
        .AUTO_TCOIL_EN(auto_en),
        .SELECT_INPUT_POLARITY_SETTING(pol),
        .DEBOUNCE_PERIOD(period),
        .SECOND_MEMORY_SELECT_INPUT(pin),
        .REQUESTED_MEMORY(req),
        .ACTIVE_MEMORY(act_slow),
        .TCOIL_ACTIVE(tc_slow)
    );

    task check(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic int eff_period(input logic [15:0] p);
        return (p == 16'h0000) ? 1 : int'(p);
    endfunction

    task print_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one telecoil visit: close, open (maybe with one bounce), then release
    task episode(input logic p, input logic [15:0] per, input logic [1:0] r, input logic b);
        int n;
        n = eff_period(per);
        @(posedge mclk);
        pol <= p;
        period <= per;
        req <= r;
        closed <= 1'b0;
        auto_en <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check("idle memory", r, act);
        @(posedge mclk);
        closed <= 1'b1;
        @(posedge mclk);
        #1 check("telecoil memory", `TCOIL_MEMORY, act);
        check("telecoil flag", 2'h1, {1'b0, tc});
        // requested memory moves meanwhile; the saved one must come back
        @(posedge mclk);
        req <= r ^ 2'h1;
        closed <= 1'b0;
        if (b) begin
            repeat (1 + ($unsigned($random(seed)) % n)) @(posedge mclk);
            closed <= 1'b1;
            @(posedge mclk);
            closed <= 1'b0;
        end
        repeat (n) @(posedge mclk);
        #1 check("held in debounce", 2'h1, {1'b0, tc});
        check("held memory", `TCOIL_MEMORY, act);
        @(posedge mclk);
        #1 check("restored memory", r, act);
        check("released flag", 2'h0, {1'b0, tc});
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1 check("reset memory", `TCOIL_MEMORY_RST, act);
        check("slow reset memory", `TCOIL_MEMORY_RST, act_slow);
        // corner cases: both polarities, zero and long periods, bounces
        episode(1'b1, 16'h0002, 2'h1, 1'b0);
        episode(1'b0, 16'h0000, 2'h2, 1'b0);
        episode(1'b0, 16'h0009, 2'h0, 1'b1);
        episode(1'b1, 16'h0001, 2'h2, 1'b1);
        repeat (20) begin
            episode(1'($random(seed)), 16'($unsigned($random(seed)) % 7),
                2'($random(seed)), 1'($random(seed)));
        end
        // let the slow copy finish its debounce, then close the switch on both
        @(posedge mclk);
        req <= 2'h1;
        closed <= 1'b0;
        repeat (30) @(posedge mclk);
        #1 check("slow idle memory", 2'h1, act_slow);
        @(posedge mclk);
        closed <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 check("telecoil memory", `TCOIL_MEMORY, act);
        check("slow telecoil memory", `TCOIL_MEMORY, act_slow);
        // feature dropped mid-telecoil: the kept memory comes back at once
        @(posedge mclk);
        auto_en <= 1'b0;
        req <= 2'h2;
        @(posedge mclk);
        #1 check("dropped memory", 2'h1, act);
        check("slow dropped memory", 2'h1, act_slow);
        // feature off: a closed switch must not move the memory
        repeat (3) @(posedge mclk);
        #1 check("disabled memory", 2'h2, act);
        check("disabled flag", 2'h0, {1'b0, tc});
        check("slow disabled memory", 2'h2, act_slow);
        check("slow disabled flag", 2'h0, {1'b0, tc_slow});
        print_verdict();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
